// File: verilog/sfsp_regs.svh
// Purpose: Register offsets, control word fields, frame layout and reset values.
// Assumes: Included by its bare name into the serial port design.
// Notes: Offsets are byte addresses on the AXI4-Lite register port.
`ifndef SFSP_REGS_SVH
`define SFSP_REGS_SVH

`define SFSP_OFF_CTRL 8'h00
`define SFSP_OFF_TEST 8'h04
`define SFSP_OFF_WORD 8'h08
`define SFSP_OFF_COUNT 8'h0C

`define SFSP_RST_CTRL 32'h0000_0000
`define SFSP_RST_TEST 32'h0000_0000

`define SFSP_FRAME_LAST 6'h2F
`define SFSP_WORD_LAST 6'h0F
`define SFSP_FILL1_LAST 6'h17
`define SFSP_WORD2_LAST 6'h27
`define SFSP_WORD2_BASE 6'h27

`define SFSP_BIT_EN 15
`define SFSP_SYM_HI 14
`define SFSP_SYM_LO 13
`define SFSP_GAIN_HI 12
`define SFSP_GAIN_LO 10
`define SFSP_BIT_LOOP 9
`define SFSP_PWR_HI 7
`define SFSP_PWR_LO 6

`define SFSP_LVL_ZERO 3'h0
`define SFSP_LVL_M3 3'h5
`define SFSP_LVL_M1 3'h7
`define SFSP_LVL_P1 3'h1
`define SFSP_LVL_P3 3'h3
`define SFSP_GAIN_MAX 3'h4

`endif

// File: verilog/sfsp_pkg.sv
// Purpose: Types shared by the serial port design and its bench.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: Numeric constants live in sfsp_regs.svh.
package sfsp_pkg;
	typedef enum logic [1:0] {
		SFSP_PWR_LOW = 2'h0,
		SFSP_PWR_MEDIUM = 2'h1,
		SFSP_PWR_NORMAL = 2'h2
	} sfsp_power_e;
	typedef logic signed [2:0] sfsp_level_t;
endpackage

// File: verilog/sfsp_serial_port.sv
// Purpose: Serial control and conversion port of a line transceiver front end.
// Assumes: All link pins are asynchronous to aclk and at most a quarter of its rate.
// Notes: Both link directions are oversampled by aclk; software sees state over AXI4-Lite.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "sfsp_regs.svh"

module sfsp_serial_port #(
	parameter int ADDR_W = 8
) (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite register port
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Transmit link pins
	input wire logic tx_symbol_clock,
	input wire logic tx_oversample_clock,
	input wire logic serial_data_in,
	// Receive link pins
	input wire logic rx_symbol_clock,
	input wire logic rx_oversample_clock,
	output logic serial_data_out,
	// Converter results, aclk domain
	input wire logic [13:0] first_conversion_word,
	input wire logic [13:0] second_conversion_word,
	// Analog settings
	output sfsp_pkg::sfsp_level_t line_level,
	output logic [3:0] receive_gain_db,
	output logic receive_gain_reserved,
	output logic line_input_connected,
	output logic hybrid_receive_input_connected,
	output sfsp_pkg::sfsp_power_e power_level
);
	import sfsp_pkg::*;

	// Pin synchronisers: bit 0..4 = tx sym, tx over, data in, rx sym, rx over.
	logic [4:0] pin_raw;
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;
	logic [4:0] pin_prev_q;
	assign pin_raw = {rx_oversample_clock, rx_symbol_clock, serial_data_in,
		tx_oversample_clock, tx_symbol_clock};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pin_meta_q[gi] <= 1'b0;
					pin_sync_q[gi] <= 1'b0;
					pin_prev_q[gi] <= 1'b0;
				end else begin
					pin_meta_q[gi] <= pin_raw[gi];
					pin_sync_q[gi] <= pin_meta_q[gi];
					pin_prev_q[gi] <= pin_sync_q[gi];
				end
			end
		end
	endgenerate

	// Each direction keeps its own edge detectors and counter.
	logic tx_rise;
	logic rx_rise;
	logic rx_fall;
	assign tx_rise = pin_sync_q[1] && !pin_prev_q[1];
	assign rx_rise = pin_sync_q[4] && !pin_prev_q[4];
	assign rx_fall = !pin_sync_q[4] && pin_prev_q[4];

	// Symbol clock level as seen at the previous oversampling rise.
	logic tx_sym_last_q;
	logic rx_sym_last_q;
	logic tx_frame_start;
	logic rx_frame_start;
	assign tx_frame_start = tx_rise && pin_sync_q[0] && !tx_sym_last_q;
	assign rx_frame_start = rx_rise && pin_sync_q[3] && !rx_sym_last_q;

	// Counters idle at the last bit until the first symbol clock rise is seen.
	logic [5:0] tx_cnt_q;
	logic [5:0] tx_idx;
	logic [5:0] rx_cnt_q;
	assign tx_idx = tx_frame_start ? 6'h00 :
		(tx_cnt_q == `SFSP_FRAME_LAST) ? tx_cnt_q : 6'(tx_cnt_q + 6'h01);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_cnt_q <= `SFSP_FRAME_LAST;
			tx_sym_last_q <= 1'b0;
		end else if (tx_rise) begin
			tx_cnt_q <= tx_idx;
			tx_sym_last_q <= pin_sync_q[0];
		end
	end

	// Control word capture.
	logic [15:0] shift_q;
	logic [15:0] shift_d;
	logic [15:0] ctrl_word_q;
	logic apply;
	assign shift_d = {shift_q[14:0], pin_sync_q[2]};
	assign apply = tx_rise && (tx_idx == `SFSP_WORD_LAST);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_q <= 16'h0000;
		end else if (tx_rise && tx_idx <= `SFSP_WORD_LAST) begin
			shift_q <= shift_d;
		end
	end

	logic [15:0] tx_words_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_word_q <= 16'h0000;
			tx_words_q <= 16'h0000;
		end else if (apply) begin
			ctrl_word_q <= shift_d;
			tx_words_q <= 16'(tx_words_q + 16'h0001);
		end
	end

	// Decoded settings; bits 5..0 below the power field drive no setting and are kept only in ctrl_word_q.
	logic [2:0] gain_code;
	logic [1:0] sym_code;
	assign gain_code = shift_d[`SFSP_GAIN_HI:`SFSP_GAIN_LO];
	assign sym_code = shift_d[`SFSP_SYM_HI:`SFSP_SYM_LO];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_level <= `SFSP_LVL_ZERO;
			receive_gain_db <= 4'h0;
			receive_gain_reserved <= 1'b0;
			line_input_connected <= 1'b1;
			power_level <= SFSP_PWR_LOW;
		end else if (apply) begin
			if (!shift_d[`SFSP_BIT_EN]) begin
				line_level <= `SFSP_LVL_ZERO;
			end else begin
				unique case (sym_code)
					2'h0: line_level <= `SFSP_LVL_M3;
					2'h1: line_level <= `SFSP_LVL_M1;
					2'h3: line_level <= `SFSP_LVL_P1;
					2'h2: line_level <= `SFSP_LVL_P3;
				endcase
			end
			// A reserved gain code keeps the last valid gain and raises a flag.
			receive_gain_reserved <= gain_code > `SFSP_GAIN_MAX;
			if (gain_code <= `SFSP_GAIN_MAX) begin
				receive_gain_db <= 4'({1'b0, gain_code} * 4'h3);
			end
			line_input_connected <= !shift_d[`SFSP_BIT_LOOP];
			unique case (shift_d[`SFSP_PWR_HI:`SFSP_PWR_LO])
				2'h0: power_level <= SFSP_PWR_LOW;
				2'h1: power_level <= SFSP_PWR_MEDIUM;
				default: power_level <= SFSP_PWR_NORMAL;
			endcase
		end
	end

	assign hybrid_receive_input_connected = 1'b1;

	// Receive side.
	logic [31:0] ctrl_q;
	logic [31:0] test_q;
	logic [15:0] word1_q;
	logic [15:0] word2_q;
	logic [15:0] rx_frames_q;
	logic [5:0] rx_idx;
	logic [5:0] rx_w2_idx;
	assign rx_idx = rx_frame_start ? 6'h00 :
		(rx_cnt_q == `SFSP_FRAME_LAST) ? rx_cnt_q : 6'(rx_cnt_q + 6'h01);
	assign rx_w2_idx = 6'(`SFSP_WORD2_BASE - rx_cnt_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_cnt_q <= `SFSP_FRAME_LAST;
			rx_sym_last_q <= 1'b0;
			rx_frames_q <= 16'h0000;
			word1_q <= 16'h0000;
			word2_q <= 16'h0000;
		end else if (rx_rise) begin
			rx_cnt_q <= rx_idx;
			rx_sym_last_q <= pin_sync_q[3];
			if (rx_frame_start) begin
				rx_frames_q <= 16'(rx_frames_q + 16'h0001);
				// With ctrl_q[0] clear, both results pass through unchanged, already two's complement.
				if (ctrl_q[0]) begin
					word1_q <= {test_q[13:0], 2'h0};
					word2_q <= {test_q[29:16], 2'h0};
				end else begin
					word1_q <= {first_conversion_word, 2'h0};
					word2_q <= {second_conversion_word, 2'h0};
				end
			end
		end
	end

	// The bit of count k is driven at the falling edge inside bit time k.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_data_out <= 1'b1;
		end else if (rx_fall) begin
			if (rx_cnt_q <= `SFSP_WORD_LAST) begin
				serial_data_out <= word1_q[4'(`SFSP_WORD_LAST - rx_cnt_q)];
			end else if (rx_cnt_q <= `SFSP_FILL1_LAST) begin
				serial_data_out <= 1'b1;
			end else if (rx_cnt_q <= `SFSP_WORD2_LAST) begin
				serial_data_out <= word2_q[rx_w2_idx[3:0]];
			end else begin
				serial_data_out <= 1'b1;
			end
		end
	end

	// AXI4-Lite slave.
	logic aw_q;
	logic w_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_go;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] wr_off;
	logic [7:0] rd_off;
	assign s_axi_awready = !aw_q;
	assign s_axi_wready = !w_q;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_q && w_q && !s_axi_bvalid;
	assign wr_off = 8'(awaddr_q);
	assign rd_off = 8'(s_axi_araddr);
	assign wr_hit = (awaddr_q >> 4) == '0;
	assign rd_hit = (s_axi_araddr >> 4) == '0;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && !aw_q) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_q) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `SFSP_RST_CTRL;
			test_q <= `SFSP_RST_TEST;
		end else if (wr_go && wr_hit) begin
			if (wr_off == `SFSP_OFF_CTRL) begin
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0001;
			end
			if (wr_off == `SFSP_OFF_TEST) begin
				test_q <= merge(test_q, wdata_q, wstrb_q) & 32'h3FFF_3FFF;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
			s_axi_rdata <= 32'h0000_0000;
			if (rd_hit) begin
				unique case (rd_off[3:0])
					4'h0: s_axi_rdata <= ctrl_q;
					4'h4: s_axi_rdata <= test_q;
					4'h8: s_axi_rdata <= {16'h0000, ctrl_word_q};
					4'hC: s_axi_rdata <= {rx_frames_q, tx_words_q};
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_tx_count_range: assert property (tx_cnt_q <= `SFSP_FRAME_LAST)
		else $error("transmit bit count beyond frame");
	a_rx_frame_zero: assert property (rx_frame_start |=> rx_cnt_q == 6'h00)
		else $error("receive frame did not restart at bit zero");
	a_window_closed: assert property ((tx_rise && tx_idx > `SFSP_WORD_LAST) |=>
		$stable(shift_q)) else $error("control input taken outside window");
	a_word_applied: assert property (apply |=> ctrl_word_q == $past(shift_d))
		else $error("captured word not applied");
	a_hold_settings: assert property (!apply |=> $stable(line_level))
		else $error("settings changed without new word");
	a_zero_symbol: assert property ((apply && !shift_d[`SFSP_BIT_EN]) |=>
		line_level == `SFSP_LVL_ZERO) else $error("disabled symbol not zero");
	a_symbol_plus3: assert property ((apply && shift_d[15:13] == 3'h6) |=>
		line_level == 3'sd3) else $error("symbol 10 not plus three");
	a_gain_six: assert property ((apply && gain_code == 3'h2) |=>
		receive_gain_db == 4'h6) else $error("gain code 010 not 6 dB");
	a_loop_inputs: assert property (apply |=>
		line_input_connected == !$past(shift_d[`SFSP_BIT_LOOP]))
		else $error("loopback did not steer line inputs");
	a_power_normal: assert property ((apply && shift_d[`SFSP_PWR_HI]) |=>
		power_level == SFSP_PWR_NORMAL) else $error("power 1x not normal");
	a_spare_low: assert property ((rx_fall && rx_cnt_q inside {6'h0E, 6'h0F}) |=>
		!serial_data_out) else $error("spare bit not low");
	a_filler_high: assert property ((rx_fall && rx_cnt_q inside {[6'h10:6'h17]}) |=>
		serial_data_out) else $error("filler bit not high");
	a_out_on_fall: assert property (!rx_fall |=> $stable(serial_data_out))
		else $error("output changed outside falling edge");

	c_word_applied: cover property (apply && shift_d[`SFSP_BIT_EN]);
	c_rx_frame: cover property (rx_frame_start ##[1:600] rx_frame_start);
	c_axi_write: cover property (wr_go && wr_hit);
	c_test_mode: cover property (rx_frame_start && ctrl_q[0]);
endmodule
`default_nettype wire

// File: tb/sfsp_dsp_model.sv
// Purpose: Transceiver processor model that drives both link clock pairs and data.
// Assumes: Both link directions run free at 80 ns per bit time.
// Notes: Bits 16..47 carry a toggling pattern that the port must ignore.
`timescale 1ns/1ps
`default_nettype none
module sfsp_dsp_model (
	// Control word to send and returned data
	input wire logic [15:0] ctrl_word,
	input wire logic serial_data_out,
	// Link pins
	output logic tx_symbol_clock,
	output logic tx_oversample_clock,
	output logic serial_data_in,
	output logic rx_symbol_clock,
	output logic rx_oversample_clock,
	// Captured traffic
	output logic [47:0] rx_frame,
	output logic [15:0] tx_frames,
	output logic [15:0] rx_frames
);
	int tx_bit = 47;
	int rx_bit = 47;
	logic [47:0] shift_q = '0;
	logic [15:0] word_q = '0;

	// The word is latched at frame start so a change from the bench never splits a frame.
	initial begin
		tx_oversample_clock = 1'b0;
		tx_symbol_clock = 1'b0;
		serial_data_in = 1'b1;
		tx_frames = '0;
		#3;
		forever begin
			#40 tx_oversample_clock = 1'b1;
			#40 tx_oversample_clock = 1'b0;
			tx_bit = (tx_bit + 1) % 48;
			if (tx_bit == 0) begin
				word_q = ctrl_word;
				tx_frames++;
			end
			tx_symbol_clock = (tx_bit < 24);
			serial_data_in = (tx_bit < 16) ? word_q[15 - tx_bit] : ~serial_data_in;
		end
	end

	// Bit k is valid at the rise of bit time k+1, so a frame completes at the next bit 0.
	initial begin
		rx_oversample_clock = 1'b0;
		rx_symbol_clock = 1'b0;
		rx_frames = '0;
		rx_frame = '0;
		#17;
		forever begin
			#40 rx_oversample_clock = 1'b1;
			if (rx_bit == 0) begin
				rx_frame = {shift_q[46:0], serial_data_out};
				rx_frames++;
			end
			shift_q = {shift_q[46:0], serial_data_out};
			#40 rx_oversample_clock = 1'b0;
			rx_bit = (rx_bit + 1) % 48;
			rx_symbol_clock = (rx_bit < 24);
		end
	end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench for the symbol front end serial port.
// Assumes: Link clocks of 80 ns per bit, unrelated in phase to aclk.
// Notes: Expected settings are worked out from the control word fields.
`timescale 1ns/1ps
`default_nettype none
`include "sfsp_regs.svh"
module tb;
	import sfsp_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic tx_symbol_clock, tx_oversample_clock, serial_data_in, serial_data_out;
	logic rx_symbol_clock, rx_oversample_clock;
	logic [13:0] first_conversion_word = '0, second_conversion_word = '0;
	sfsp_level_t line_level;
	logic [3:0] receive_gain_db, exp_gain;
	logic receive_gain_reserved, line_input_connected, hybrid_receive_input_connected;
	sfsp_power_e power_level;
	logic [15:0] ctrl_word = '0, tx_frames, rx_frames, w;
	logic [47:0] rx_frame;
	logic [2:0] g, lv;
	int n_errors = 0;
	int n_tests = 0;
	int i;

	sfsp_serial_port #(.ADDR_W(8)) u_sfsp_serial_port (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .tx_symbol_clock, .tx_oversample_clock, .serial_data_in,
		.rx_symbol_clock, .rx_oversample_clock, .serial_data_out, .first_conversion_word,
		.second_conversion_word, .line_level, .receive_gain_db, .receive_gain_reserved,
		.line_input_connected, .hybrid_receive_input_connected, .power_level);
	sfsp_dsp_model u_sfsp_dsp_model (.ctrl_word, .serial_data_out, .tx_symbol_clock,
		.tx_oversample_clock, .serial_data_in, .rx_symbol_clock, .rx_oversample_clock,
		.rx_frame, .tx_frames, .rx_frames);

	initial forever #5 aclk = ~aclk;

	task automatic wrap_up();
		if (n_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic lost();
		n_errors++;
		$display("BAD %0t no answer", $time);
		wrap_up();
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 60; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (k == 60) lost();
		s_axi_bready <= 1'b0;
		chk(48'(s_axi_bresp), 48'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int k;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 60; k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (k == 60) lost();
		s_axi_rready <= 1'b0;
		chk({14'h0, s_axi_rresp, s_axi_rdata}, {14'h0, er, ed});
	endtask
	// Three frames, since a change may land just after the port sampled a frame start.
	task automatic frames(input bit rx);
		logic [15:0] s;
		int k;
		s = rx ? rx_frames : tx_frames;
		for (k = 0; k < 1500; k++) begin
			@(posedge aclk);
			if (16'((rx ? rx_frames : tx_frames) - s) >= 16'd3) break;
		end
		if (k == 1500) lost();
	endtask
	function automatic logic [47:0] fr(input logic [13:0] a, input logic [13:0] b);
		return {a, 2'b00, 8'hFF, b, 2'b00, 8'hFF};
	endfunction

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		chk(48'({line_level, receive_gain_db, power_level, line_input_connected}), 48'(3'h1));
		rd(`SFSP_OFF_CTRL, `SFSP_RST_CTRL, 2'b00);
		rd(`SFSP_OFF_TEST, `SFSP_RST_TEST, 2'b00);
		rd(8'h10, 32'h0000_0000, 2'b10);
		wr(8'h10, 32'hFFFF_FFFF, 2'b10);
		wr(`SFSP_OFF_TEST, 32'h2000_1FFF, 2'b00);
		rd(`SFSP_OFF_TEST, 32'h2000_1FFF, 2'b00);
		// Only the two low byte lanes may change under a partial strobe.
		s_axi_wstrb <= 4'h3;
		wr(`SFSP_OFF_TEST, 32'h1555_0AAA, 2'b00);
		s_axi_wstrb <= 4'hF;
		rd(`SFSP_OFF_TEST, 32'h2000_0AAA, 2'b00);
		wr(`SFSP_OFF_TEST, 32'h2000_1FFF, 2'b00);
		exp_gain = 4'h0;
		for (i = 0; i < 9; i++) begin
			g = 3'(i % 8);
			w = {i != 3, i[1:0], g, i[0], i[2], i[1:0], 6'h25 ^ i[5:0]};
			case (w[14:13])
				2'b00: lv = `SFSP_LVL_M3;
				2'b01: lv = `SFSP_LVL_M1;
				2'b11: lv = `SFSP_LVL_P1;
				default: lv = `SFSP_LVL_P3;
			endcase
			if (!w[15]) lv = `SFSP_LVL_ZERO;
			if (g <= `SFSP_GAIN_MAX) exp_gain = 4'(g * 3);
			ctrl_word <= w;
			frames(1'b0);
			chk({45'h0, line_level}, {45'h0, lv});
			chk(48'(receive_gain_db), 48'(exp_gain));
			chk(48'({receive_gain_reserved, line_input_connected}),
				48'({g > 3'h4, !w[9]}));
			chk(48'(hybrid_receive_input_connected), 48'(1'b1));
			chk(48'(power_level), 48'(w[7:6] == 2'b00 ? SFSP_PWR_LOW :
				w[7:6] == 2'b01 ? SFSP_PWR_MEDIUM : SFSP_PWR_NORMAL));
			rd(`SFSP_OFF_WORD, {16'h0, w}, 2'b00);
		end
		for (i = 0; i < 2; i++) begin
			first_conversion_word <= i ? 14'h0000 : 14'h1FFF;
			second_conversion_word <= i ? 14'h2AC3 : 14'h2000;
			frames(1'b1);
			chk(rx_frame,
				i ? fr(14'h0000, 14'h2AC3) : fr(14'h1FFF, 14'h2000));
		end
		wr(`SFSP_OFF_CTRL, 32'h0000_0001, 2'b00);
		rd(`SFSP_OFF_CTRL, 32'h0000_0001, 2'b00);
		frames(1'b1);
		chk(rx_frame, fr(14'h1FFF, 14'h2000));
		wrap_up();
	end
endmodule
`default_nettype wire
